// file: rtl/mcr_pkg.sv
// Shared constants, types and helpers of the meter command and config block
package mcr_pkg;

  // Data and address widths
  localparam int DW    = 24;             // Register word width
  localparam int AW    = 10;             // Host address width (byte mode)
  localparam int IW    = 8;              // Word index width
  localparam int CH_N  = 6;              // Calibration channels
  localparam int MF_N  = 10;             // Multiplier fields
  localparam int MV_W  = 3;              // Decoded multiplier width

  // Register space
  localparam logic [AW-1:0] WORDS          = 10'h100;  // 256 words
  localparam logic [AW-1:0] BYTES_PER_WORD = 10'h003;  // 24-bit words
  localparam logic [IW-1:0] CMD_IDX        = 8'h00;    // command_word
  localparam logic [IW-1:0] CLR_IDX        = 8'h24;    // clear_actions
  localparam logic [IW-1:0] SETUP_IDX      = 8'h25;    // input_setup

  // Reset values
  localparam logic [DW-1:0] CMD_RST   = 24'h000000;
  localparam logic [DW-1:0] CLR_RST   = 24'h000000;
  localparam logic [DW-1:0] SETUP_RST = 24'h000000;

  // Command codes
  localparam logic [11:0] OP_ACCESS  = 12'hACC;
  localparam logic [3:0]  SUB_ERASE0 = 4'h0;
  localparam logic [3:0]  SUB_ERASE1 = 4'h1;
  localparam logic [7:0]  OP_CAL     = 8'hCA;
  localparam logic [7:0]  OP_SRST    = 8'hBD;
  localparam logic [15:0] SRST_LOW   = 16'h0000;

  // Field positions
  localparam int OFFSET_BIT  = 9;        // Offset instead of gain
  localparam int HALT_BIT    = 6;        // halt_line_rate_update
  localparam int LOCK_BIT    = 5;        // cycle_locked_accum
  localparam int TCOMP_BIT   = 4;        // temp_gain_comp
  localparam int ACCUM_BIT   = 2;        // Clear accumulators and frame
  localparam int ENERGY_BIT  = 1;        // Clear energy counters
  localparam int MINMAX_BIT  = 0;        // Restart min/max tracking
  localparam int VREF_HI     = 23;       // Voltage reference select
  localparam int VREF_LO     = 22;

  // Sequencer states
  typedef enum {ST_IDLE, ST_FLASH, ST_CAL, ST_SRST} mcr_state_t;

  // Channel vector: s2, s0, s3, s1, die temperature, outside gain
  function automatic logic [CH_N-1:0] mcr_cal_sel(input logic [DW-1:0] w);
    mcr_cal_sel = {w[14], w[13], w[12], w[11], w[10], w[8]};
  endfunction

  // Places a channel vector back into bits 15:8, offset bit zero
  function automatic logic [7:0] mcr_cal_bits(input logic [CH_N-1:0] c);
    mcr_cal_bits = {1'b0, c[5], c[4], c[3], c[2], c[1], 1'b0, c[0]};
  endfunction

  // Two-bit multiplier code to signed value -1, 0, 1, 2
  function automatic logic [MV_W-1:0] mcr_mult(input logic [1:0] f);
    mcr_mult = {1'b0, f} - 3'h1;
  endfunction

endpackage

// file: rtl/mcr_addr_map.sv
// Host address to word index translation for byte or word addressing
module mcr_addr_map
  import mcr_pkg::*;
(
  input  wire logic [mcr_pkg::AW-1:0] addr_in,
  input  wire logic                   byte_mode_in,
  output logic      [mcr_pkg::IW-1:0] word_idx_out,
  output logic                        mapped_out
);

  logic [AW-1:0] quot;                   // Byte address divided by three
  logic [AW-1:0] rem;                    // Leftover bytes within a word

  // Byte mode needs a whole-word boundary; word mode takes the index
  always_comb begin
    quot = addr_in / BYTES_PER_WORD;
    rem  = AW'(addr_in - AW'(quot * BYTES_PER_WORD));
    if (byte_mode_in) begin
      word_idx_out = quot[IW-1:0];
      mapped_out   = (rem == '0) && (quot < WORDS);
    end else begin
      word_idx_out = addr_in[IW-1:0];
      mapped_out   = addr_in < WORDS;
    end
  end

endmodule

// file: rtl/mcr_cmd_regs.sv
// Command, clear-action and input setup registers with command sequencer
// What this block does
// - ACC0 command erases stored coefficient part zero
// - ACC1 command erases stored coefficient part one
// - Next reset loads factory defaults for erased parts
// - Erase done zeroes bits 23:8, keeps settings
// - CA command calibrates every selected channel
// - Select bits map channels; host keeps bit 15 zero
// - Bit 9 selects offset calibration, not gain
// - Calibration end clears opcode and succeeded selects
// - Low byte carries general settings with command
// - BD command with zero low bits soft-resets
// - Clear bit 2 zeroes accumulators and frame count
// - Bit 1 clears counters; bit 0 restarts min/max
// - Setup bits 23:22 choose voltage reference
// - Setup bits 19:0 hold sensor multiplier fields
// - Multiplier codes mean -1, 0, 1, 2
// - 256 words of 24 bits behind host ports
// - Byte addresses on UART, word addresses otherwise
// - Only command, clear and setup accept writes
// - Integer registers are plain 24-bit unsigned
// - Fixed-point values are 24-bit two's complement
// - Command register sits at word zero
// - Settings bit 6 halts line-rate update
module mcr_cmd_regs (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  // Register access from the host port engines
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic                       byte_mode_in,
  input  wire logic [mcr_pkg::AW-1:0]     reg_addr_in,
  input  wire logic [mcr_pkg::DW-1:0]     reg_wdata_in,
  output logic      [mcr_pkg::DW-1:0]     reg_rdata_out,
  output logic                            reg_ack_out,
  output logic                            busy_out,
  // Nonvolatile store
  output logic                            erase_part0_out,
  output logic                            erase_part1_out,
  input  wire logic                       flash_done_in,
  input  wire logic [1:0]                 flash_blank_in,
  output logic                            load_defaults_out,
  output logic      [1:0]                 factory_sel_out,
  output logic                            soft_reset_out,
  // Calibration engine
  output logic                            cal_start_out,
  output logic                            cal_offset_out,
  output logic      [mcr_pkg::CH_N-1:0]   cal_chan_out,
  input  wire logic                       cal_done_in,
  input  wire logic [mcr_pkg::CH_N-1:0]   cal_fail_in,
  // General settings
  output logic                            halt_line_rate_update_out,
  output logic                            cycle_locked_accum_out,
  output logic                            temp_gain_comp_out,
  // Clear actions
  output logic                            clear_accum_frame_out,
  output logic                            clear_energy_cnt_out,
  output logic                            restart_minmax_out,
  // Input setup
  output logic      [1:0]                 volt_ref_sel_out,
  output logic [mcr_pkg::MF_N*mcr_pkg::MV_W-1:0] mult_val_out
);
  import mcr_pkg::*;
  // Assertions below sample on this clock and sleep through reset
  default clocking cb_main @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [IW-1:0] word_idx;               // Translated word index
  logic          addr_ok;                // Address lands on a word
  logic          hit_cmd;                // Access to command_word
  logic          hit_clr;                // Access to clear_actions
  logic          hit_setup;              // Access to input_setup
  logic          wr_cmd;                 // Accepted command write
  logic          wr_clr;                 // Write to clear_actions
  logic [DW-1:0] command_word;           // Command and settings
  logic [DW-1:0] clear_actions;          // Clear request bits
  logic [DW-1:0] input_setup;            // Reference and multipliers
  mcr_state_t    state;                  // Sequencer state
  logic          go;                     // Decode request pulse
  logic          boot;                   // First cycle after reset
  logic          is_erase0;              // Decoded commands
  logic          is_erase1;
  logic          is_cal;
  logic          is_srst;
  logic          done_now;               // Command finishes this cycle

  // Byte or word address translation
  mcr_addr_map u_map (
    .addr_in      (reg_addr_in),
    .byte_mode_in (byte_mode_in),
    .word_idx_out (word_idx),
    .mapped_out   (addr_ok)
  );

  // Address decode of the writable words
  assign hit_cmd   = addr_ok && (word_idx == CMD_IDX);
  assign hit_clr   = addr_ok && (word_idx == CLR_IDX);
  assign hit_setup = addr_ok && (word_idx == SETUP_IDX);
  // A new command is only taken while nothing runs
  assign wr_cmd    = reg_wr_in && hit_cmd && !busy_out;
  assign wr_clr    = reg_wr_in && hit_clr;

  // Command decode from the stored word
  assign is_erase0 = (command_word[23:12] == OP_ACCESS)
                  && (command_word[11:8] == SUB_ERASE0);
  assign is_erase1 = (command_word[23:12] == OP_ACCESS)
                  && (command_word[11:8] == SUB_ERASE1);
  assign is_cal    = command_word[23:16] == OP_CAL;
  assign is_srst   = (command_word[23:16] == OP_SRST)
                  && (command_word[15:0] == SRST_LOW);

  // Completion of the running command
  assign done_now = ((state == ST_FLASH) && flash_done_in)
                 || ((state == ST_CAL) && cal_done_in)
                 || (state == ST_SRST)
                 || ((state == ST_IDLE) && go
                     && !(is_erase0 || is_erase1 || is_cal || is_srst));

  // Command register: host write, then bits 23:8 cleared when an erase or soft reset completes, and bits 23:8 but failed selects when a calibration completes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      command_word <= CMD_RST;
    end else if (wr_cmd) begin
      command_word <= reg_wdata_in;
    end else if (((state == ST_FLASH) && flash_done_in)
                 || (state == ST_SRST)) begin
      command_word[23:8] <= '0;
    end else if ((state == ST_CAL) && cal_done_in) begin
      // Failed channels keep their select bit
      command_word[23:16] <= '0;
      command_word[15:8]  <= mcr_cal_bits(
        mcr_cal_sel(command_word) & cal_fail_in);
    end
  end

  // Busy flag and decode request
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      go       <= 1'b0;
    end else begin
      go       <= wr_cmd;
      // Set on an accepted command, held until the command finishes
      busy_out <= wr_cmd || (busy_out && !done_now);
    end
  end

  // Sequencer: start pulses and wait for the engines
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state           <= ST_IDLE;
      erase_part0_out <= 1'b0;
      erase_part1_out <= 1'b0;
      cal_start_out   <= 1'b0;
      cal_offset_out  <= 1'b0;
      cal_chan_out    <= '0;
      soft_reset_out  <= 1'b0;
    end else begin
      erase_part0_out <= 1'b0;
      erase_part1_out <= 1'b0;
      cal_start_out   <= 1'b0;
      soft_reset_out  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (go && is_erase0) begin
            erase_part0_out <= 1'b1;
            state           <= ST_FLASH;
          end else if (go && is_erase1) begin
            erase_part1_out <= 1'b1;
            state           <= ST_FLASH;
          end else if (go && is_cal) begin
            cal_start_out  <= 1'b1;
            cal_chan_out   <= mcr_cal_sel(command_word);
            cal_offset_out <= command_word[OFFSET_BIT];
            state          <= ST_CAL;
          end else if (go && is_srst) begin
            soft_reset_out <= 1'b1;
            state          <= ST_SRST;
          end
        end
        ST_FLASH: begin
          if (flash_done_in) begin
            state <= ST_IDLE;
          end
        end
        ST_CAL: begin
          if (cal_done_in) begin
            state <= ST_IDLE;
          end
        end
        ST_SRST: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Default load after power-up or soft reset, per erased part
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      boot              <= 1'b1;
      load_defaults_out <= 1'b0;
      factory_sel_out   <= 2'h0;
    end else begin
      boot              <= 1'b0;
      load_defaults_out <= boot || (state == ST_SRST);
      if (boot || (state == ST_SRST)) begin
        factory_sel_out <= flash_blank_in;
      end
    end
  end

  // General settings applied with every command
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      halt_line_rate_update_out <= 1'b0;
      cycle_locked_accum_out    <= 1'b0;
      temp_gain_comp_out        <= 1'b0;
    end else begin
      halt_line_rate_update_out <= command_word[HALT_BIT];
      cycle_locked_accum_out    <= command_word[LOCK_BIT];
      temp_gain_comp_out        <= command_word[TCOMP_BIT];
    end
  end

  // Clear actions: one pulse per set bit, bits then self-clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      clear_actions         <= CLR_RST;
      clear_accum_frame_out <= 1'b0;
      clear_energy_cnt_out  <= 1'b0;
      restart_minmax_out    <= 1'b0;
    end else begin
      // Reserved bits 23:3 never store
      clear_actions <= wr_clr ? {21'h0, reg_wdata_in[2:0]} : CLR_RST;
      clear_accum_frame_out <= wr_clr && reg_wdata_in[ACCUM_BIT];
      clear_energy_cnt_out  <= wr_clr && reg_wdata_in[ENERGY_BIT];
      restart_minmax_out    <= wr_clr && reg_wdata_in[MINMAX_BIT];
    end
  end

  // Input setup register and its reference select
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      input_setup      <= SETUP_RST;
      volt_ref_sel_out <= 2'h0;
    end else begin
      if (reg_wr_in && hit_setup) begin
        input_setup <= reg_wdata_in;
      end
      volt_ref_sel_out <= input_setup[VREF_HI:VREF_LO];
    end
  end

  // One decoded multiplier per two-bit field of bits 19:0
  for (genvar i = 0; i < MF_N; i++) begin : g_mult
    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
        mult_val_out[i*MV_W +: MV_W] <= '0;
      end else begin
        mult_val_out[i*MV_W +: MV_W] <=
          mcr_mult(input_setup[2*i +: 2]);
      end
    end
  end

  // Read answer; unmapped and output words read as zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reg_ack_out   <= 1'b0;
      reg_rdata_out <= '0;
    end else begin
      reg_ack_out   <= reg_wr_in || reg_rd_in;
      reg_rdata_out <= '0;
      if (reg_rd_in && hit_cmd) begin
        reg_rdata_out <= command_word;
      end else if (reg_rd_in && hit_clr) begin
        reg_rdata_out <= clear_actions;
      end else if (reg_rd_in && hit_setup) begin
        reg_rdata_out <= input_setup;
      end
    end
  end

  // Checks on the sequencer and the register effects
  a_erase_zero_go: assert property (
    wr_cmd && (reg_wdata_in[23:8] == {OP_ACCESS, SUB_ERASE0})
    |-> ##2 erase_part0_out && !erase_part1_out)
    else $error("erase part zero not started");
  a_erase_one_go: assert property (
    wr_cmd && (reg_wdata_in[23:8] == {OP_ACCESS, SUB_ERASE1})
    |-> ##2 erase_part1_out && !erase_part0_out)
    else $error("erase part one not started");
  a_erase_done_wipe: assert property (
    (state == ST_FLASH) && flash_done_in
    |=> (command_word[23:8] == '0)
        && (command_word[7:0] == $past(command_word[7:0])))
    else $error("erase completion left command bits");
  a_cal_start_sel: assert property (
    wr_cmd && (reg_wdata_in[23:16] == OP_CAL)
    |-> ##2 cal_start_out
        && (cal_chan_out == mcr_cal_sel($past(reg_wdata_in, 2)))
        && (cal_offset_out == $past(reg_wdata_in[OFFSET_BIT], 2)))
    else $error("calibration start or selection wrong");
  a_cal_end_keep: assert property (
    (state == ST_CAL) && cal_done_in
    |=> (command_word[23:16] == '0)
        && (mcr_cal_sel(command_word) ==
            ($past(cal_fail_in) & $past(cal_chan_out))) && !busy_out)
    else $error("calibration completion bits wrong");
  a_soft_reset_go: assert property (
    wr_cmd && (reg_wdata_in[23:16] == OP_SRST)
    && (reg_wdata_in[15:0] == SRST_LOW)
    |-> ##2 soft_reset_out ##1 load_defaults_out)
    else $error("soft reset sequence wrong");
  a_clear_accum: assert property (
    wr_clr |=> (clear_accum_frame_out == $past(reg_wdata_in[ACCUM_BIT]))
               ##1 !clear_accum_frame_out || $past(wr_clr))
    else $error("accumulator clear pulse wrong");
  a_clear_minmax: assert property (
    $rose(restart_minmax_out) || $rose(clear_energy_cnt_out)
    |-> $past(wr_clr))
    else $error("clear pulse without a write");
  a_vref_follow: assert property (
    reg_wr_in && hit_setup
    |-> ##2 volt_ref_sel_out == $past(reg_wdata_in[VREF_HI:VREF_LO], 2))
    else $error("voltage reference select not applied");
  // Skips the edges where the decoder still shows its reset value
  a_mult_decode: assert property (
    $past(rst_n_in) && ($past(input_setup[1:0]) == 2'h0)
    |-> mult_val_out[2:0] == 3'h7)
    else $error("multiplier code zero not minus one");

endmodule

// file: tb/mcr_far_model.sv
// Flash store and calibration engine model facing the command block
module mcr_far_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       erase0_in,
  input  wire logic       erase1_in,
  input  wire logic       cal_start_in,
  input  wire logic [5:0] cal_chan_in,
  input  wire logic [5:0] fail_mask_in,
  input  wire logic [3:0] dly_in,
  output logic            flash_done_out,
  output logic      [1:0] blank_out,
  output logic            cal_done_out,
  output logic      [5:0] cal_fail_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       fbusy;  // Erase in progress
  logic       cbusy;  // Calibration in progress
  logic [3:0] fcnt;   // Erase cycles left
  logic [3:0] ccnt;   // Calibration cycles left
  logic [1:0] pend;   // Parts being erased

  // Stored parts are nonvolatile, so logic reset leaves them alone
  initial begin
    blank_out = 2'h0;
    cal_fail_out = 6'h00;
  end

  // Erase and calibration sequencing with programmable latency
  always @(posedge clk_in) begin
    flash_done_out <= 1'b0;
    cal_done_out <= 1'b0;
    // Fail flags toggle outside the done cycle so stale values never pass
    cal_fail_out <= ~cal_fail_out;
    if (!rst_n_in) begin
      fbusy <= 1'b0;
      cbusy <= 1'b0;
    end else begin
      if (erase0_in || erase1_in) begin
        fbusy <= 1'b1;
        fcnt <= dly_in;
        pend <= {erase1_in, erase0_in};
      end else if (fbusy && fcnt == 4'h0) begin
        fbusy <= 1'b0;
        flash_done_out <= 1'b1;
        blank_out <= blank_out | pend;
      end else if (fbusy) begin
        fcnt <= fcnt - 4'h1;
      end
      if (cal_start_in) begin
        cbusy <= 1'b1;
        ccnt <= dly_in;
      end else if (cbusy && ccnt == 4'h0) begin
        cbusy <= 1'b0;
        cal_done_out <= 1'b1;
        cal_fail_out <= cal_chan_in & fail_mask_in;
      end else if (cbusy) begin
        ccnt <= ccnt - 4'h1;
      end
    end
  end
endmodule

// file: tb/mcr_cmd_regs_test.sv
// Self-checking bench for the command and configuration registers
module mcr_cmd_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import mcr_pkg::*;

  logic        ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in, byte_mode_in;
  logic [9:0]  reg_addr_in;
  logic [23:0] reg_wdata_in, reg_rdata_out;
  logic        reg_ack_out, busy_out, erase_part0_out, erase_part1_out;
  logic        flash_done_in, load_defaults_out, soft_reset_out;
  logic        cal_start_out, cal_offset_out, cal_done_in;
  logic [1:0]  flash_blank_in, factory_sel_out, volt_ref_sel_out;
  logic [5:0]  cal_chan_out, cal_fail_in, fail_mask;
  logic        halt_out, lock_out, tcomp_out, clr_acc, clr_en, clr_mm;
  logic [29:0] mult_val_out;
  logic [3:0]  dly;                 // Partner latency
  logic        mode;                // Byte addressing for next access
  logic        rd_prev;             // Read strobe seen last cycle
  logic [23:0] w;                   // Word under test
  logic [23:0] exp_q[$];            // Expected read data, oldest first
  int          miscompares, check_count, i, j, k;
  logic [31:0] seed;
  localparam logic [2:0] MT[4] = '{3'h7, 3'h0, 3'h1, 3'h2};

  mcr_cmd_regs uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .byte_mode_in(byte_mode_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_ack_out(reg_ack_out), .busy_out(busy_out),
    .erase_part0_out(erase_part0_out), .erase_part1_out(erase_part1_out),
    .flash_done_in(flash_done_in), .flash_blank_in(flash_blank_in),
    .load_defaults_out(load_defaults_out), .factory_sel_out(factory_sel_out),
    .soft_reset_out(soft_reset_out), .cal_start_out(cal_start_out),
    .cal_offset_out(cal_offset_out), .cal_chan_out(cal_chan_out),
    .cal_done_in(cal_done_in), .cal_fail_in(cal_fail_in),
    .halt_line_rate_update_out(halt_out), .cycle_locked_accum_out(lock_out),
    .temp_gain_comp_out(tcomp_out), .clear_accum_frame_out(clr_acc),
    .clear_energy_cnt_out(clr_en), .restart_minmax_out(clr_mm),
    .volt_ref_sel_out(volt_ref_sel_out), .mult_val_out(mult_val_out));

  mcr_far_model far (.clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .erase0_in(erase_part0_out), .erase1_in(erase_part1_out),
    .cal_start_in(cal_start_out), .cal_chan_in(cal_chan_out),
    .fail_mask_in(fail_mask), .dly_in(dly), .flash_done_out(flash_done_in),
    .blank_out(flash_blank_in), .cal_done_out(cal_done_in),
    .cal_fail_out(cal_fail_in));

  // Free-running 200 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // Compare one result and count it
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Report and end the run
  task automatic stop_test;
    chk(24'(exp_q.size()), 24'h0);
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read monitor: every acked read takes the oldest expectation
  initial rd_prev = 1'b0;
  always @(negedge ref_clk_in) begin
    if (reg_ack_out === 1'b1 && rd_prev) begin
      if (exp_q.size() > 0) begin
        chk(reg_rdata_out, exp_q.pop_front());
      end else begin
        // An answer with nothing expected is a mismatch by itself
        chk(24'(exp_q.size()), 24'h1);
      end
    end
    rd_prev = reg_rd_in;
  end

  // One register access: strobe for a single cycle
  task automatic acc(input logic wr, input logic [9:0] a,
                     input logic [23:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= wr;
    reg_rd_in <= !wr;
    byte_mode_in <= mode;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 24'h0);
  endtask

  task automatic nc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // Wait for the sequencer to go idle, bounded
  task automatic idle;
    int n;
    nc(1);
    for (n = 0; n < 300 && busy_out !== 1'b0; n++) nc(1);
    if (busy_out !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask

  // Main sequence
  initial begin
    seed = 32'h569492d5;
    {rst_n_in, reg_wr_in, reg_rd_in, byte_mode_in, mode} = '0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    fail_mask = '0;
    dly = 4'h3;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    nc(2);
    chk(24'({load_defaults_out, factory_sel_out}), 24'h4);
    rd(10'(CMD_IDX), 24'h0);
    rd(10'(CLR_IDX), 24'h0);
    rd(10'(SETUP_IDX), 24'h0);
    // Each clear action alone, then reserved bits only
    for (i = 0; i < 4; i++) begin
      w = (i < 3) ? 24'(1 << i) : 24'hFFFFF8;
      wr_one(10'(CLR_IDX), w);
      nc(1);
      chk(24'({clr_acc, clr_en, clr_mm}), w & 24'h7);
      nc(1);
      chk(24'({clr_acc, clr_en, clr_mm}), 24'h0);
    end
    // Every reference choice with random multiplier fields
    for (k = 0; k < 4; k++) begin
      w = 24'($random(seed));
      w[23:22] = k[1:0];
      wr_one(10'(SETUP_IDX), w);
      nc(2);
      chk(24'(volt_ref_sel_out), 24'(k));
      for (i = 0; i < 10; i++) begin
        chk(24'(mult_val_out[3*i+:3]), 24'(MT[w[2*i+:2]]));
      end
      rd(10'(SETUP_IDX), w);
      mode = 1'b1;
      rd(10'h06F, w);
      rd(10'h070, 24'h0);
      mode = 1'b0;
      rd(10'h0FF, 24'h0);
    end
    // Erase pair, then soft reset loads factory defaults
    wr_one(10'h0, 24'hACC040);
    nc(2);
    chk(24'(erase_part0_out), 24'h1);
    idle();
    rd(10'h0, 24'h000040);
    chk(24'(halt_out), 24'h1);
    wr_one(10'h0, 24'hACC130);
    nc(2);
    chk(24'(erase_part1_out), 24'h1);
    idle();
    rd(10'h0, 24'h000030);
    chk(24'({halt_out, lock_out, tcomp_out}), 24'h3);
    wr_one(10'h0, 24'hBD0000);
    nc(2);
    chk(24'(soft_reset_out), 24'h1);
    nc(1);
    chk(24'({load_defaults_out, factory_sel_out}), 24'h7);
    idle();
    // A code with no action only carries its settings byte
    wr_one(10'h0, 24'h000410);
    idle();
    rd(10'h0, 24'h000410);
    chk(24'({halt_out, lock_out, tcomp_out}), 24'h1);
    // Gain then offset calibration; second one is hit by a refused write
    for (j = 0; j < 2; j++) begin
      fail_mask = 6'($random(seed));
      dly = (j == 1) ? 4'hF : 4'h2;
      w = 24'hCA0000 | (24'($random(seed)) & 24'h007DFF) | 24'(j << 9);
      wr_one(10'h0, w);
      nc(2);
      chk(24'(cal_start_out), 24'h1);
      chk(24'(cal_chan_out), 24'({w[14:10], w[8]}));
      chk(24'(cal_offset_out), 24'(j));
      if (j == 1) wr_one(10'h0, 24'hBD0000);
      idle();
      rd(10'h0, {9'h0, w[14:10] & fail_mask[5:1], 1'b0,
                 w[8] & fail_mask[0], w[7:0]});
    end
    nc(3);
    stop_test();
  end

  task automatic wr_one(input logic [9:0] a, input logic [23:0] d);
    acc(1'b1, a, d);
  endtask
endmodule
